/* File: logic/efc_params.svh */
`ifndef EFC_PARAMS_SVH
`define EFC_PARAMS_SVH

`define EFC_ADDR_ALARM_CTRL    8'h1A
`define EFC_ADDR_BUFFER_CTRL   8'h1B
`define EFC_RESET_BYTE         8'h00
`define EFC_ALARM_CTRL_MASK    8'hFC
`define EFC_BUFFER_CTRL_MASK   8'hF2

`define EFC_BIT_ERR_PERIOD     7
`define EFC_BIT_VIOL_TYPE      6
`define EFC_BIT_AUTO_AIS       5
`define EFC_BIT_AUTO_FAR_END   4
`define EFC_BIT_SERIAL_CTRL    3
`define EFC_BIT_FAILOVER       2

`define EFC_BIT_TX_BUFFER      7
`define EFC_BIT_TCB_FUNC       6
`define EFC_BIT_TIDLE_FUNC     5
`define EFC_BIT_REALIGN        4
`define EFC_BIT_BP_RATE        1

`define EFC_FRAME_NS           125000
`define EFC_LONG_PERIOD_NS     1000000000
`define EFC_SHORT_PERIOD_NS    62500000
`define EFC_LONG_FRAMES        (`EFC_LONG_PERIOD_NS / `EFC_FRAME_NS)
`define EFC_SHORT_FRAMES       (`EFC_SHORT_PERIOD_NS / `EFC_FRAME_NS)

`define EFC_MCLK_PERIOD_NS     10
`define EFC_CLK_LOSS_NS        2000
`define EFC_CLK_LOSS_CYCLES    (`EFC_CLK_LOSS_NS / `EFC_MCLK_PERIOD_NS)

`endif

/* File: logic/efc_pkg.sv */
package efc_pkg;
    typedef logic [7:0]  efc_byte_t;
    typedef logic [15:0] efc_count_t;
endpackage : efc_pkg

/* File: logic/efc_clkmon_if.sv */
`timescale 1ns/10ps
interface efc_clkmon_if;
    logic clock_level;
    logic clock_lost;

    modport monitor (input clock_level, output clock_lost);
    modport user    (output clock_level, input clock_lost);
endinterface : efc_clkmon_if

/* File: logic/efc_clock_monitor.sv */
`timescale 1ns/10ps
`include "efc_params.svh"
module efc_clock_monitor #(
    parameter int LOSS_CYCLES = `EFC_CLK_LOSS_CYCLES
) (
    input wire logic       MCLK,
    input wire logic       RESET_N,
    efc_clkmon_if.monitor  mon
);
    import efc_pkg::*;

    localparam int CW = $clog2(LOSS_CYCLES + 1);

    if (LOSS_CYCLES < 2) begin : g_bad_loss
        $error("efc_clock_monitor: LOSS_CYCLES must be at least 2");
    end

    logic          level_prev;
    logic [CW-1:0] idle_count;
    logic          lost;
    wire           edge_seen = mon.clock_level ^ level_prev;
    wire           at_limit  = (idle_count == CW'(LOSS_CYCLES - 1));

    // lost once the clock has held one level for LOSS_CYCLES cycles
    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            level_prev <= 1'b0;
            idle_count <= '0;
            lost       <= 1'b0;
        end else begin
            level_prev <= mon.clock_level;
            if (edge_seen) begin
                idle_count <= '0;
                lost       <= 1'b0;
            end else if (at_limit) begin
                lost       <= 1'b1;
            end else begin
                idle_count <= idle_count + 1'b1;
            end
        end
    end

    assign mon.clock_lost = lost;
endmodule : efc_clock_monitor

/* File: logic/efc_common_control.sv */
// Overview of operation
// - period bit 0 updates error counters each second, 1 every 500 frames.
// - violation counter counts bipolar violations at 0, code violations at 1.
// - either automatic alarm enable watches sync loss, all-ones and carrier loss.
// - any receive failure sends all-ones or far-end alarm per enable bit.
// - with failover enabled, a stopped transmit clock switches to receive clock.
// - transmit buffer bit routes data through or around transmit elastic store.
// - idle function bit 0 makes idle registers mark idle-code channels.
// - idle function bit 1 marks channels taking receive serial data.
// - realign bit falling from 1 to 0 resets both elastic store depths.
`timescale 1ns/10ps
`include "efc_params.svh"
module efc_common_control #(
    parameter int LONG_FRAMES  = `EFC_LONG_FRAMES,
    parameter int SHORT_FRAMES = `EFC_SHORT_FRAMES,
    parameter int LOSS_CYCLES  = `EFC_CLK_LOSS_CYCLES
) (
    input  wire logic               MCLK,
    input  wire logic               RESET_N,
    input  wire logic               CS_N,
    input  wire logic               RD_N,
    input  wire logic               WR_N,
    input  wire efc_pkg::efc_byte_t ADDR,
    input  wire efc_pkg::efc_byte_t DATA_IN,
    output efc_pkg::efc_byte_t      DATA_OUT,
    output logic                    DATA_OE_N,
    input  wire logic               FRAME_TICK,
    input  wire logic               BIPOLAR_VIOLATION,
    input  wire logic               CODE_VIOLATION,
    input  wire logic               RX_LOSS_OF_SYNC,
    input  wire logic               RX_ALL_ONES,
    input  wire logic               RX_LOSS_OF_CARRIER,
    input  wire logic               RX_DATA,
    input  wire logic               LINE_TRANSMIT_CLOCK,
    output logic                    ERR_COUNT_UPDATE,
    output efc_pkg::efc_count_t     VIOLATION_COUNT,
    output logic                    TX_FORCE_ALL_ONES,
    output logic                    TX_FAR_END_ALARM,
    output logic                    RECEIVE_SERIAL_DATA,
    output logic                    TX_CLOCK_FROM_RX,
    output logic                    TX_BUFFER_ENABLE,
    output logic                    TX_BLOCK_INSERT_SELECT,
    output logic                    TX_IDLE_INSERT_RX_DATA,
    output logic                    BUFFER_REALIGN,
    output logic                    TX_BACKPLANE_2048
);
    import efc_pkg::*;

    localparam int FW = $clog2(LONG_FRAMES + 1);

    if (LONG_FRAMES < 2 || SHORT_FRAMES < 2 || SHORT_FRAMES > LONG_FRAMES) begin : g_bad_frames
        $error("efc_common_control: frame counts must be 2 or more, short not above long");
    end

    // parallel port pins cross into MCLK through two flops
    logic      cs_n_s1, cs_n_s2, cs_n_s3;
    logic      rd_n_s1, rd_n_s2;
    logic      wr_n_s1, wr_n_s2, wr_n_s3;
    efc_byte_t addr_s1, addr_s2;
    efc_byte_t data_s1, data_s2;
    logic      line_clk_s1, line_clk_s2;

    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            {cs_n_s1, cs_n_s2, cs_n_s3} <= 3'h7;
            {rd_n_s1, rd_n_s2}          <= 2'h3;
            {wr_n_s1, wr_n_s2, wr_n_s3} <= 3'h7;
            {addr_s1, addr_s2}          <= 16'h0000;
            {data_s1, data_s2}          <= 16'h0000;
            {line_clk_s1, line_clk_s2}  <= 2'h0;
        end else begin
            cs_n_s1 <= CS_N;
            cs_n_s2 <= cs_n_s1;
            cs_n_s3 <= cs_n_s2;
            rd_n_s1 <= RD_N;
            rd_n_s2 <= rd_n_s1;
            wr_n_s1 <= WR_N;
            wr_n_s2 <= wr_n_s1;
            wr_n_s3 <= wr_n_s2;
            addr_s1 <= ADDR;
            addr_s2 <= addr_s1;
            data_s1 <= DATA_IN;
            data_s2 <= data_s1;
            line_clk_s1 <= LINE_TRANSMIT_CLOCK;
            line_clk_s2 <= line_clk_s1;
        end
    end

    // a write is taken at the rising edge of the write strobe
    wire write_fire  = wr_n_s2 & ~wr_n_s3 & ~cs_n_s3;
    wire sel_alarm   = (addr_s2 == `EFC_ADDR_ALARM_CTRL);
    wire sel_buffer  = (addr_s2 == `EFC_ADDR_BUFFER_CTRL);
    wire read_active = ~cs_n_s2 & ~rd_n_s2;

    efc_byte_t alarm_ctrl;
    efc_byte_t buffer_ctrl;
    // unassigned bits are never stored and read back as zero
    wire efc_byte_t next_alarm_ctrl  = (write_fire && sel_alarm) ?
                                       (data_s2 & `EFC_ALARM_CTRL_MASK) : alarm_ctrl;
    wire efc_byte_t next_buffer_ctrl = (write_fire && sel_buffer) ?
                                       (data_s2 & `EFC_BUFFER_CTRL_MASK) : buffer_ctrl;
    wire efc_byte_t next_data_out    = sel_alarm  ? alarm_ctrl  :
                                       sel_buffer ? buffer_ctrl : `EFC_RESET_BYTE;

    wire err_period_short = alarm_ctrl[`EFC_BIT_ERR_PERIOD];
    wire viol_type_code   = alarm_ctrl[`EFC_BIT_VIOL_TYPE];
    wire auto_ais         = alarm_ctrl[`EFC_BIT_AUTO_AIS];
    wire auto_far_end     = alarm_ctrl[`EFC_BIT_AUTO_FAR_END];
    wire serial_force     = alarm_ctrl[`EFC_BIT_SERIAL_CTRL];
    wire failover_enable  = alarm_ctrl[`EFC_BIT_FAILOVER];
    wire realign_bit      = buffer_ctrl[`EFC_BIT_REALIGN];

    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            alarm_ctrl  <= `EFC_RESET_BYTE;
            buffer_ctrl <= `EFC_RESET_BYTE;
            DATA_OUT    <= `EFC_RESET_BYTE;
            DATA_OE_N   <= 1'b1;
        end else begin
            alarm_ctrl  <= next_alarm_ctrl;
            buffer_ctrl <= next_buffer_ctrl;
            DATA_OUT    <= next_data_out;
            DATA_OE_N   <= ~read_active;
        end
    end

    // error counter update period, counted in frames
    logic [FW-1:0] frame_count;
    wire  [FW-1:0] frame_limit = err_period_short ? FW'(SHORT_FRAMES) : FW'(LONG_FRAMES);
    wire           update_now  = FRAME_TICK && (frame_count >= frame_limit - 1'b1);
    wire  [FW-1:0] next_frame_count = update_now ? '0 :
                                      FRAME_TICK ? frame_count + 1'b1 : frame_count;

    // selected violation source feeds the accumulator
    efc_count_t    violation_acc;
    wire           viol_inc = viol_type_code ? CODE_VIOLATION : BIPOLAR_VIOLATION;
    wire           acc_full = &violation_acc;
    wire efc_count_t next_violation_acc = update_now ? efc_count_t'(viol_inc) :
                                          (acc_full ? violation_acc :
                                           violation_acc + efc_count_t'(viol_inc));

    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            frame_count      <= '0;
            violation_acc    <= '0;
            VIOLATION_COUNT  <= '0;
            ERR_COUNT_UPDATE <= 1'b0;
        end else begin
            frame_count      <= next_frame_count;
            violation_acc    <= next_violation_acc;
            ERR_COUNT_UPDATE <= update_now;
            if (update_now) begin
                VIOLATION_COUNT <= violation_acc;
            end
        end
    end

    // automatic alarms; all-ones wins if software sets both enables
    wire rx_failure     = RX_LOSS_OF_SYNC | RX_ALL_ONES | RX_LOSS_OF_CARRIER;
    wire next_force_ais = rx_failure & auto_ais;
    wire next_far_end   = rx_failure & auto_far_end & ~auto_ais;
    wire next_serial    = (serial_force & RX_LOSS_OF_SYNC) | RX_DATA;

    efc_clkmon_if clkmon ();
    assign clkmon.clock_level = line_clk_s2;

    efc_clock_monitor #(
        .LOSS_CYCLES (LOSS_CYCLES)
    ) u_clock_monitor (
        .MCLK    (MCLK),
        .RESET_N (RESET_N),
        .mon     (clkmon.monitor)
    );

    logic realign_prev;

    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            TX_FORCE_ALL_ONES      <= 1'b0;
            TX_FAR_END_ALARM       <= 1'b0;
            RECEIVE_SERIAL_DATA    <= 1'b0;
            TX_CLOCK_FROM_RX       <= 1'b0;
            TX_BUFFER_ENABLE       <= 1'b0;
            TX_BLOCK_INSERT_SELECT <= 1'b0;
            TX_IDLE_INSERT_RX_DATA <= 1'b0;
            TX_BACKPLANE_2048      <= 1'b0;
            BUFFER_REALIGN         <= 1'b0;
            realign_prev           <= 1'b0;
        end else begin
            TX_FORCE_ALL_ONES      <= next_force_ais;
            TX_FAR_END_ALARM       <= next_far_end;
            RECEIVE_SERIAL_DATA    <= next_serial;
            TX_CLOCK_FROM_RX       <= failover_enable & clkmon.clock_lost;
            TX_BUFFER_ENABLE       <= buffer_ctrl[`EFC_BIT_TX_BUFFER];
            TX_BLOCK_INSERT_SELECT <= buffer_ctrl[`EFC_BIT_TCB_FUNC];
            TX_IDLE_INSERT_RX_DATA <= buffer_ctrl[`EFC_BIT_TIDLE_FUNC];
            TX_BACKPLANE_2048      <= buffer_ctrl[`EFC_BIT_BP_RATE];
            realign_prev           <= realign_bit;
            BUFFER_REALIGN         <= realign_prev & ~realign_bit;
        end
    end

    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RESET_N);

    a_update_period: assert property (ERR_COUNT_UPDATE |->
        $past(FRAME_TICK) && ($past(frame_count) >= $past(frame_limit) - 1'b1))
        else $error("error counter update out of period");
    a_viol_source: assert property ((!update_now && !acc_full) |=>
        violation_acc == $past(violation_acc) + efc_count_t'($past(viol_inc)))
        else $error("violation accumulator missed its selected source");
    a_alarm_quiet: assert property (!(auto_ais || auto_far_end) |=>
        !TX_FORCE_ALL_ONES && !TX_FAR_END_ALARM)
        else $error("alarm sent with automatic alarms off");
    a_ais_sent: assert property ((rx_failure && auto_ais) |=> TX_FORCE_ALL_ONES)
        else $error("all-ones alarm not sent for receive failure");
    a_far_end_sent: assert property ((RX_LOSS_OF_CARRIER && auto_far_end && !auto_ais)
        |=> TX_FAR_END_ALARM && !TX_FORCE_ALL_ONES)
        else $error("far-end alarm not sent for carrier loss");
    a_serial_pass: assert property (!serial_force
        |=> RECEIVE_SERIAL_DATA == $past(RX_DATA))
        else $error("receive serial data altered while passing through");
    a_serial_forced: assert property ((serial_force && RX_LOSS_OF_SYNC)
        |=> RECEIVE_SERIAL_DATA)
        else $error("receive serial data not forced during frame loss");
    a_failover_off: assert property (!failover_enable |=> !TX_CLOCK_FROM_RX)
        else $error("clock switched with failover disabled");
    a_failover_used: assert property ((failover_enable && clkmon.clock_lost)
        |=> TX_CLOCK_FROM_RX)
        else $error("clock not switched after transmit clock loss");
    a_realign_once: assert property ($fell(realign_bit)
        |=> BUFFER_REALIGN ##1 !BUFFER_REALIGN)
        else $error("realign strobe missing or too long");
    a_realign_cause: assert property ($rose(BUFFER_REALIGN)
        |-> $past(realign_prev, 1) && !$past(realign_bit))
        else $error("realign strobe without falling realign bit");

    c_short_update: cover property (err_period_short && ERR_COUNT_UPDATE);
    c_ais_alarm:    cover property (TX_FORCE_ALL_ONES);
    c_failover:     cover property ($rose(TX_CLOCK_FROM_RX));
    c_realign:      cover property (BUFFER_REALIGN);
endmodule : efc_common_control

/* File: bench/efc_host_model.sv */
`timescale 1ns/10ps
`include "efc_params.svh"
module efc_host_model (
    input  wire logic               mclk,
    output logic                    cs_n,
    output logic                    rd_n,
    output logic                    wr_n,
    output efc_pkg::efc_byte_t      addr,
    output efc_pkg::efc_byte_t      data_in,
    input  wire efc_pkg::efc_byte_t data_out,
    input  wire logic               data_oe_n
);
    import efc_pkg::*;
    initial begin
        cs_n = 1'b1;
        rd_n = 1'b1;
        wr_n = 1'b1;
        addr = 8'h00;
        data_in = 8'h00;
    end
    task automatic hold(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : hold
    // strobes held four cycles low and four high, data held past the rising strobe
    task automatic write_reg(input efc_byte_t a, input efc_byte_t d);
        efc_byte_t v;
        if (a == `EFC_ADDR_ALARM_CTRL) begin
            v = d & `EFC_ALARM_CTRL_MASK;
        end else begin
            v = d & `EFC_BUFFER_CTRL_MASK;
        end
        if (a == `EFC_ADDR_ALARM_CTRL && v[`EFC_BIT_AUTO_AIS]) begin
            v[`EFC_BIT_AUTO_FAR_END] = 1'b0;
        end
        cs_n = 1'b0;
        addr = a;
        data_in = v;
        wr_n = 1'b0;
        hold(4);
        wr_n = 1'b1;
        hold(4);
        cs_n = 1'b1;
        data_in = ~v;
        hold(4);
    endtask : write_reg
    task automatic read_reg(input efc_byte_t a, output efc_byte_t d, output logic oe_n);
        cs_n = 1'b0;
        rd_n = 1'b0;
        addr = a;
        hold(4);
        d = data_out;
        oe_n = data_oe_n;
        rd_n = 1'b1;
        cs_n = 1'b1;
        hold(4);
    endtask : read_reg
endmodule : efc_host_model

/* File: bench/test_e1_framer_common_control.sv */
`timescale 1ns/10ps
`define CHECK(got, exp) begin comparisons++; if ((got) !== (exp)) begin fail_count++; \
    $display("BAD t=%0t got=%h exp=%h", $time, got, exp); end end
module test_e1_framer_common_control;
    import efc_pkg::*;
    localparam int LONG = 20;
    localparam int SHORT = 5;
    logic       mclk, reset_n, cs_n, rd_n, wr_n, data_oe_n, frame_tick, bip_viol, code_viol;
    logic       rx_los, rx_ais, rx_loc, rx_data, ltc, line_clk_run, upd, ones, far, rsd;
    logic       from_rx, tx_buf, tcb_sel, idle_sel, realign, bp_2048, rd_oe;
    efc_byte_t  addr, data_in, data_out, rd_val;
    efc_count_t viol;
    int         fail_count, comparisons, realign_pulses;
    efc_common_control #(.LONG_FRAMES(LONG), .SHORT_FRAMES(SHORT), .LOSS_CYCLES(8)) dut (
        .MCLK(mclk), .RESET_N(reset_n), .CS_N(cs_n), .RD_N(rd_n), .WR_N(wr_n),
        .ADDR(addr), .DATA_IN(data_in), .DATA_OUT(data_out), .DATA_OE_N(data_oe_n),
        .FRAME_TICK(frame_tick), .BIPOLAR_VIOLATION(bip_viol), .CODE_VIOLATION(code_viol),
        .RX_LOSS_OF_SYNC(rx_los), .RX_ALL_ONES(rx_ais), .RX_LOSS_OF_CARRIER(rx_loc),
        .RX_DATA(rx_data), .LINE_TRANSMIT_CLOCK(ltc), .ERR_COUNT_UPDATE(upd),
        .VIOLATION_COUNT(viol), .TX_FORCE_ALL_ONES(ones), .TX_FAR_END_ALARM(far),
        .RECEIVE_SERIAL_DATA(rsd), .TX_CLOCK_FROM_RX(from_rx), .TX_BUFFER_ENABLE(tx_buf),
        .TX_BLOCK_INSERT_SELECT(tcb_sel), .TX_IDLE_INSERT_RX_DATA(idle_sel),
        .BUFFER_REALIGN(realign), .TX_BACKPLANE_2048(bp_2048));
    efc_host_model host (.mclk(mclk), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .addr(addr),
        .data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n));
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    // line transmit clock toggles every two cycles while allowed to run
    initial forever begin
        repeat (2) @(posedge mclk);
        #1;
        if (line_clk_run) ltc = ~ltc;
    end
    // counted mid-cycle so the one-cycle strobe is seen once and settled
    always @(negedge mclk) if (realign === 1'b1) realign_pulses++;
    task automatic step(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : step
    task automatic expect_reg(input efc_byte_t a, input efc_byte_t exp);
        host.read_reg(a, rd_val, rd_oe);
        `CHECK(rd_oe, 1'b0)
        `CHECK(rd_val, exp)
    endtask : expect_reg
    task automatic check_reset;
        `CHECK({upd, ones, far, from_rx, tx_buf, realign, data_oe_n}, 7'h01)
        expect_reg(8'h1A, 8'h00);
        expect_reg(8'h1B, 8'h00);
        expect_reg(8'h1C, 8'h00);
    endtask : check_reset
    // five-cycle frames: tick, update sample, violation, idle, violation plus code violation
    task automatic check_period(input efc_byte_t sel, input int frames);
        int last;
        int seen;
        last = -1;
        seen = 0;
        host.write_reg(8'h1A, sel);
        for (int i = 0; i < 3 * frames + 2; i++) begin
            frame_tick = 1'b1;
            step(1);
            frame_tick = 1'b0;
            if (upd === 1'b1) begin
                if (last >= 0) begin
                    `CHECK(i - last, frames)
                    `CHECK(viol, 16'(sel[6] ? frames : 2 * frames))
                    seen++;
                end
                last = i;
            end
            step(1);
            bip_viol = 1'b1;
            step(1);
            bip_viol = 1'b0;
            step(1);
            bip_viol = 1'b1;
            code_viol = 1'b1;
            step(1);
            bip_viol = 1'b0;
            code_viol = 1'b0;
        end
        `CHECK(seen >= 2, 1'b1)
    endtask : check_period
    task automatic check_alarms;
        efc_byte_t en [3] = '{8'h20, 8'h10, 8'h00};
        for (int e = 0; e < 3; e++) begin
            host.write_reg(8'h1A, en[e]);
            for (int c = 0; c < 3; c++) begin
                {rx_los, rx_ais, rx_loc} = 3'h4 >> c;
                step(2);
                `CHECK({ones, far}, {en[e][5], en[e][4]})
                {rx_los, rx_ais, rx_loc} = 3'h0;
                step(2);
                `CHECK({ones, far}, 2'h0)
            end
        end
    endtask : check_alarms
    task automatic check_receive_serial_data;
        host.write_reg(8'h1A, 8'h08);
        rx_los = 1'b1;
        step(2);
        `CHECK(rsd, 1'b1)
        rx_los = 1'b0;
        step(2);
        `CHECK(rsd, 1'b0)
        rx_data = 1'b1;
        step(2);
        `CHECK(rsd, 1'b1)
        rx_data = 1'b0;
        host.write_reg(8'h1A, 8'h00);
        rx_los = 1'b1;
        step(2);
        `CHECK(rsd, 1'b0)
        rx_los = 1'b0;
    endtask : check_receive_serial_data
    task automatic check_backplane;
        efc_byte_t vals [5] = '{8'h80, 8'h40, 8'h20, 8'h02, 8'hE2};
        for (int b = 0; b < 5; b++) begin
            host.write_reg(8'h1B, vals[b]);
            expect_reg(8'h1B, vals[b]);
            `CHECK({tx_buf, tcb_sel, idle_sel}, vals[b][7:5])
            `CHECK(bp_2048, vals[b][1])
        end
    endtask : check_backplane
    task automatic check_failover;
        for (int en = 1; en >= 0; en--) begin
            host.write_reg(8'h1A, en[0] ? 8'h04 : 8'h00);
            line_clk_run = 1'b0;
            step(30);
            `CHECK(from_rx, en[0])
            line_clk_run = 1'b1;
            step(20);
            `CHECK(from_rx, 1'b0)
        end
    endtask : check_failover
    task automatic check_realign;
        int n0;
        n0 = realign_pulses;
        host.write_reg(8'h1B, 8'h10);
        `CHECK(realign_pulses - n0, 0)
        host.write_reg(8'h1B, 8'h00);
        step(4);
        `CHECK(realign_pulses - n0, 1)
        host.write_reg(8'h1B, 8'h00);
        `CHECK(realign_pulses - n0, 1)
    endtask : check_realign
    task automatic give_verdict;
        $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : give_verdict
    initial begin
        #200000;
        fail_count++;
        give_verdict;
    end
    initial begin
        {frame_tick, bip_viol, code_viol, rx_los, rx_ais, rx_loc, rx_data, ltc} = 8'h00;
        line_clk_run = 1'b1;
        fail_count = 0;
        comparisons = 0;
        realign_pulses = 0;
        reset_n = 1'b0;
        step(20);
        reset_n = 1'b1;
        step(1);
        check_reset;
        host.write_reg(8'h1A, 8'h00);
        host.write_reg(8'h1B, 8'h02);
        check_period(8'hC0, SHORT);
        check_period(8'h00, LONG);
        check_alarms;
        check_receive_serial_data;
        check_backplane;
        check_failover;
        check_realign;
        reset_n = 1'b0;
        step(2);
        reset_n = 1'b1;
        step(1);
        check_reset;
        give_verdict;
    end
endmodule : test_e1_framer_common_control
